//--- rtl/ubs_pkg.sv
// Purpose: Shared constants and types for the dual UART baud/status block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register offsets not multiples of four are kept as indices
package ubs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_TIMER2_UART0_CLOCK_SELECT_U0 = 12'h418;
    localparam logic [11:0] IDX_TIMER2_UART1_CLOCK_SELECT_U1 = 12'h419;
    localparam logic [11:0] IDX_PRESCALE = 12'h440;
    localparam logic [11:0] IDX_STAT0 = 12'h448;
    localparam logic [11:0] IDX_STAT1 = 12'h449;
    localparam logic [11:0] IDX_CTRL0 = 12'h44a;
    localparam logic [11:0] IDX_CTRL1 = 12'h44b;
    localparam logic [11:0] IDX_RBUF0 = 12'h44c;
    localparam logic [11:0] IDX_RBUF1 = 12'h44d;
    localparam logic [11:0] IDX_RELOAD1 = 12'h44e;
    localparam logic [11:0] IDX_RELOAD2 = 12'h44f;
    // Field positions
    localparam int RX_T2_BIT = 5;
    localparam int TX_T2_BIT = 4;
    localparam int PT_HI_BIT = 3;
    localparam int PT_LO_BIT = 2;
    localparam int FE_BIT = 3;
    localparam int BR_BIT = 2;
    localparam int OE_BIT = 1;
    localparam int STINT_BIT = 0;
    // Control register: mode [1:0], multiproc [2], rx enable [3], rx flag [4], t1 mode0 [5]
    localparam int CTL_MP_BIT = 2;
    localparam int CTL_REN_BIT = 3;
    localparam int CTL_RI_BIT = 4;
    localparam int CTL_T1W_BIT = 5;
    localparam logic [7:0] STAT_RESET = 8'h00;
    // Fixed divisions and timer ranges
    localparam logic [5:0] DIV_MODE0 = 6'h10;
    localparam logic [5:0] DIV_MODE2 = 6'h20;
    localparam logic [6:0] PRE_DIV4 = 7'h04;
    localparam logic [6:0] PRE_DIV16 = 7'h10;
    localparam logic [6:0] PRE_DIV64 = 7'h40;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    // Interrupt arbitration slots
    localparam logic [3:0] SLOT_U0_RX = 4'h7;
    localparam logic [3:0] SLOT_U0_TX = 4'h8;
    localparam logic [3:0] SLOT_U1_RX = 4'h9;
    localparam logic [3:0] SLOT_U1_TX = 4'ha;
    localparam logic [7:0] VEC_U0_RX = 8'ha0;

    typedef enum logic [1:0] {
        UBS_MODE0 = 2'b00,
        UBS_MODE1 = 2'b01,
        UBS_MODE2 = 2'b10,
        UBS_MODE3 = 2'b11
    } ubs_mode_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } ubs_rx_state_t;

    // Interrupt request bundle per UART
    typedef struct packed {
        logic rx;
        logic tx;
    } ubs_irq_t;
endpackage

//--- rtl/ubs_core.sv
// Purpose: Baud clocking, receive framing, extended status and multiproc filter
// Assumes: Single 50 MHz clock, APB register access, two UART receivers
// Notes: Transmit shifter lives elsewhere; tx ticks are exported for it
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Contract
// - Modes 0 and 2 use fixed oscillator division; modes 1, 3 timer overflow.
// - Sampling tick runs at sixteen times the bit rate.
// - Mode 0 bit rate is osc/16; mode 2 bit rate is osc/32.
// - Prescaler codes 00,01,10 give osc/4, osc/16, osc/64; 11 reserved.
// - Timer modes: baud is overflow/16; ranges 256 or 65536.
// - Highest timer-driven bit rate is osc/64.
// - Timer 2 select bits 5 and 4 route rx and tx per UART.
// - Timer 2 counts prescaled ticks; other UART may use timer 1.
// - Framing error flag set on missing stop bit; software clears.
// - Break flag set when all bits including stop are low.
// - Overrun flag set when new byte lands while receive flag set.
// - Separate rx and tx requests, slots 7 to 10, vector A0h first.
// - Modes 2 and 3 capture nine data bits, ninth kept separately.
// - With multiproc enable in modes 2, 3, interrupt only when ninth bit is 1; the code still raises the rx request on enabled error flags.
// - Multiproc enable ignored in mode 0; in mode 1 needs valid stop.
// - Buffer write loads transmit, read returns separate receive register.
// - Mode 1 frame: start, eight data LSB first, stop; modes 2, 3 add ninth.
module ubs_core #(
    parameter int NUM_UART = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [NUM_UART-1:0] rxd_i,
    output logic [NUM_UART-1:0] tx_tick_o,
    output logic [NUM_UART-1:0] tx_load_o,
    output logic [7:0] tx_data_o,
    output ubs_pkg::ubs_irq_t [NUM_UART-1:0] irq_o,
    output logic [3:0] irq_slot_o
);
    logic [7:0] t2_u0_reg;
    logic [7:0] t2_u1_reg;
    logic [7:0] scr_reg;
    logic [7:0] stat_reg [NUM_UART];
    logic [7:0] ctl_reg [NUM_UART];
    logic [8:0] rbuf_reg [NUM_UART];
    logic [7:0] reload1_reg;
    logic [15:0] reload2_reg;
    logic [6:0] pre_cnt_reg;
    logic pre_tick;
    logic [15:0] t1_cnt_reg;
    logic [15:0] t2_cnt_reg;
    logic t1_ovf_reg;
    logic t2_ovf_reg;
    logic [5:0] fix_cnt_reg;
    logic fix16_tick;
    logic fix32_tick;
    logic [NUM_UART-1:0] rx_tick;
    logic [NUM_UART-1:0] tx_tick;
    logic [2:0] sync_reg [NUM_UART];
    logic [NUM_UART-1:0] rxd_s;
    logic wr_en;
    logic rd_en;
    logic [11:0] idx;

    // Map an APB byte address to a register index
    function automatic logic [11:0] reg_index(input logic [31:0] a);
        reg_index = a[13:2];
    endfunction

    // Prescaler code to divisor; zero marks the reserved code
    function automatic logic [6:0] pre_div(input logic [1:0] code);
        case (code)
            2'b00: pre_div = ubs_pkg::PRE_DIV4;
            2'b01: pre_div = ubs_pkg::PRE_DIV16;
            2'b10: pre_div = ubs_pkg::PRE_DIV64;
            default: pre_div = 7'h00;
        endcase
    endfunction

    assign idx = reg_index(paddr_i);
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_en = psel_i & penable_i & ~pwrite_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_cnt_reg <= 7'h00;
        end else if (pre_div(scr_reg[ubs_pkg::PT_HI_BIT:ubs_pkg::PT_LO_BIT]) == 7'h00 ||
            pre_cnt_reg >= pre_div(scr_reg[ubs_pkg::PT_HI_BIT:ubs_pkg::PT_LO_BIT]) - 7'h01) begin
            // Also catches a count left above a newly chosen, smaller divisor
            pre_cnt_reg <= 7'h00;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 7'h01;
        end
    end
    assign pre_tick = (pre_div(scr_reg[ubs_pkg::PT_HI_BIT:ubs_pkg::PT_LO_BIT]) != 7'h00) &&
        (pre_cnt_reg == pre_div(scr_reg[ubs_pkg::PT_HI_BIT:ubs_pkg::PT_LO_BIT]) - 7'h01);

    // Timer 1: 8-bit auto-reload or 16-bit count
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            t1_cnt_reg <= 16'h0000;
            t1_ovf_reg <= 1'b0;
        end else begin
            t1_ovf_reg <= 1'b0;
            // Reload write also presets the count, so a new rate starts at once
            if (wr_en && idx == ubs_pkg::IDX_RELOAD1) begin
                t1_cnt_reg <= {8'h00, pwdata_i[7:0]};
            end else if (pre_tick) begin
                if (ctl_reg[0][ubs_pkg::CTL_T1W_BIT]) begin
                    t1_cnt_reg <= t1_cnt_reg + 16'h0001;
                    t1_ovf_reg <= (t1_cnt_reg == 16'hffff);
                end else if (t1_cnt_reg[7:0] == 8'hff) begin
                    t1_cnt_reg <= {8'h00, reload1_reg};
                    t1_ovf_reg <= 1'b1;
                end else begin
                    t1_cnt_reg <= {8'h00, t1_cnt_reg[7:0] + 8'h01};
                end
            end
        end
    end

    // Timer 2 counts prescaled ticks with 16-bit reload
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            t2_cnt_reg <= 16'h0000;
            t2_ovf_reg <= 1'b0;
        end else begin
            t2_ovf_reg <= 1'b0;
            if (wr_en && idx == ubs_pkg::IDX_RELOAD2) begin
                t2_cnt_reg <= pwdata_i[15:0];
            end else if (pre_tick) begin
                if (t2_cnt_reg == 16'hffff) begin
                    t2_cnt_reg <= reload2_reg;
                    t2_ovf_reg <= 1'b1;
                end else begin
                    t2_cnt_reg <= t2_cnt_reg + 16'h0001;
                end
            end
        end
    end

    // Fixed oscillator division; sixteen ticks make one bit
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fix_cnt_reg <= 6'h00;
        end else if (fix_cnt_reg == ubs_pkg::DIV_MODE2 - 6'h01) begin
            fix_cnt_reg <= 6'h00;
        end else begin
            fix_cnt_reg <= fix_cnt_reg + 6'h01;
        end
    end
    // Osc/16 bit rate needs a tick each cycle; osc/32 every second
    assign fix16_tick = 1'b1;
    assign fix32_tick = fix_cnt_reg[0];

    // Pick clock per UART and direction
    always_comb begin
        for (int u = 0; u < NUM_UART; u++) begin
            logic [7:0] sel;
            sel = (u == 0) ? t2_u0_reg : t2_u1_reg;
            case (ubs_pkg::ubs_mode_t'(ctl_reg[u][1:0]))
                ubs_pkg::UBS_MODE0: begin
                    rx_tick[u] = fix16_tick;
                    tx_tick[u] = fix16_tick;
                end
                ubs_pkg::UBS_MODE2: begin
                    rx_tick[u] = fix32_tick;
                    tx_tick[u] = fix32_tick;
                end
                default: begin
                    rx_tick[u] = sel[ubs_pkg::RX_T2_BIT] ? t2_ovf_reg : t1_ovf_reg;
                    tx_tick[u] = sel[ubs_pkg::TX_T2_BIT] ? t2_ovf_reg : t1_ovf_reg;
                end
            endcase
        end
    end

    // Three-stage synchroniser on serial inputs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int u = 0; u < NUM_UART; u++) sync_reg[u] <= 3'b111;
        end else begin
            for (int u = 0; u < NUM_UART; u++) sync_reg[u] <= {sync_reg[u][1:0], rxd_i[u]};
        end
    end
    // Stage one is never read here; line level moves when stages two and three agree
    logic [NUM_UART-1:0] rxd_hold_reg;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rxd_hold_reg <= '1;
        end else begin
            for (int u = 0; u < NUM_UART; u++)
                if (sync_reg[u][1] == sync_reg[u][2]) rxd_hold_reg[u] <= sync_reg[u][2];
        end
    end
    assign rxd_s = rxd_hold_reg;

    // Receivers, status and registers per UART
    ubs_pkg::ubs_rx_state_t st_reg [NUM_UART];
    logic [3:0] ovs_reg [NUM_UART];
    logic [3:0] bit_reg [NUM_UART];
    logic [8:0] sh_reg [NUM_UART];
    logic [NUM_UART-1:0] all_low_reg;
    logic [NUM_UART-1:0] frame_done;
    logic [NUM_UART-1:0] stop_ok;
    logic [NUM_UART-1:0] got_bit8;

    // Frame receiver, sampled mid-bit on tick 8 of 16
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int u = 0; u < NUM_UART; u++) begin
                st_reg[u] <= ubs_pkg::RX_IDLE;
                ovs_reg[u] <= 4'h0;
                bit_reg[u] <= 4'h0;
                sh_reg[u] <= 9'h000;
                all_low_reg[u] <= 1'b0;
            end
        end else begin
            for (int u = 0; u < NUM_UART; u++) begin
                if (rx_tick[u]) begin
                    ovs_reg[u] <= ovs_reg[u] + 4'h1;
                    case (st_reg[u])
                        ubs_pkg::RX_IDLE: begin
                            ovs_reg[u] <= 4'h0;
                            if (!rxd_s[u] && ctl_reg[u][ubs_pkg::CTL_REN_BIT] &&
                                ctl_reg[u][1:0] != 2'b00) begin
                                st_reg[u] <= ubs_pkg::RX_START;
                            end
                        end
                        ubs_pkg::RX_START: begin
                            if (ovs_reg[u] == ubs_pkg::OVS_MID) begin
                                st_reg[u] <= rxd_s[u] ? ubs_pkg::RX_IDLE : ubs_pkg::RX_DATA;
                                ovs_reg[u] <= 4'h0;
                                bit_reg[u] <= 4'h0;
                                all_low_reg[u] <= 1'b1;
                            end
                        end
                        ubs_pkg::RX_DATA: begin
                            if (ovs_reg[u] == ubs_pkg::OVS_LAST) begin
                                // Ninth bit kept in top of shifter
                                sh_reg[u] <= {rxd_s[u], sh_reg[u][8:1]};
                                all_low_reg[u] <= all_low_reg[u] & ~rxd_s[u];
                                bit_reg[u] <= bit_reg[u] + 4'h1;
                                if (bit_reg[u] == (ctl_reg[u][1] ? 4'h8 : 4'h7))
                                    st_reg[u] <= ubs_pkg::RX_STOP;
                            end
                        end
                        ubs_pkg::RX_STOP: begin
                            if (ovs_reg[u] == ubs_pkg::OVS_LAST) st_reg[u] <= ubs_pkg::RX_IDLE;
                        end
                        default: st_reg[u] <= ubs_pkg::RX_IDLE;
                    endcase
                end
            end
        end
    end

    always_comb begin
        for (int u = 0; u < NUM_UART; u++) begin
            frame_done[u] = rx_tick[u] && st_reg[u] == ubs_pkg::RX_STOP &&
                ovs_reg[u] == ubs_pkg::OVS_LAST;
            stop_ok[u] = rxd_s[u];
            // Data bit 8 captured: last data sample of 8-bit frame
            got_bit8[u] = rx_tick[u] && st_reg[u] == ubs_pkg::RX_DATA &&
                ovs_reg[u] == ubs_pkg::OVS_LAST && bit_reg[u] == 4'h7;
        end
    end

    // Received byte, ninth bit and receive-complete flag
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int u = 0; u < NUM_UART; u++) begin
                rbuf_reg[u] <= 9'h000;
                ctl_reg[u] <= 8'h00;
            end
        end else begin
            for (int u = 0; u < NUM_UART; u++) begin
                logic mp_ok;
                mp_ok = 1'b1;
                if (wr_en && idx == (u == 0 ? ubs_pkg::IDX_CTRL0 : ubs_pkg::IDX_CTRL1))
                    ctl_reg[u] <= pwdata_i[7:0];
                if (frame_done[u]) begin
                    if (ctl_reg[u][ubs_pkg::CTL_MP_BIT]) begin
                        case (ubs_pkg::ubs_mode_t'(ctl_reg[u][1:0]))
                            ubs_pkg::UBS_MODE1: mp_ok = stop_ok[u];
                            ubs_pkg::UBS_MODE2, ubs_pkg::UBS_MODE3: mp_ok = sh_reg[u][8];
                            default: mp_ok = 1'b1;
                        endcase
                    end
                    if (mp_ok) begin
                        // Ninth bit, or stop bit in mode 1
                        rbuf_reg[u] <= ctl_reg[u][1] ? sh_reg[u] :
                            {stop_ok[u], sh_reg[u][8:1]};
                        ctl_reg[u][ubs_pkg::CTL_RI_BIT] <= 1'b1;
                    end
                end
            end
        end
    end

    // Sticky status flags; set wins over software clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int u = 0; u < NUM_UART; u++) stat_reg[u] <= ubs_pkg::STAT_RESET;
        end else begin
            for (int u = 0; u < NUM_UART; u++) begin
                logic [7:0] nxt;
                nxt = stat_reg[u];
                if (wr_en && idx == (u == 0 ? ubs_pkg::IDX_STAT0 : ubs_pkg::IDX_STAT1))
                    nxt = {4'h0, pwdata_i[3:0]};
                if (frame_done[u] && !stop_ok[u]) nxt[ubs_pkg::FE_BIT] = 1'b1;
                if (frame_done[u] && !stop_ok[u] && all_low_reg[u]) nxt[ubs_pkg::BR_BIT] = 1'b1;
                if (got_bit8[u] && ctl_reg[u][ubs_pkg::CTL_RI_BIT]) nxt[ubs_pkg::OE_BIT] = 1'b1;
                stat_reg[u] <= nxt;
            end
        end
    end

    // Baud configuration registers and transmit buffer load
    // Writes to buffer go to transmit side only
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            t2_u0_reg <= 8'h00;
            t2_u1_reg <= 8'h00;
            scr_reg <= 8'h00;
            reload1_reg <= 8'h00;
            reload2_reg <= 16'h0000;
            tx_load_o <= '0;
            tx_data_o <= 8'h00;
        end else begin
            tx_load_o <= '0;
            if (wr_en) begin
                case (idx)
                    ubs_pkg::IDX_TIMER2_UART0_CLOCK_SELECT_U0: t2_u0_reg <= pwdata_i[7:0];
                    ubs_pkg::IDX_TIMER2_UART1_CLOCK_SELECT_U1: t2_u1_reg <= pwdata_i[7:0];
                    ubs_pkg::IDX_PRESCALE: scr_reg <= pwdata_i[7:0];
                    ubs_pkg::IDX_RELOAD1: reload1_reg <= pwdata_i[7:0];
                    ubs_pkg::IDX_RELOAD2: reload2_reg <= pwdata_i[15:0];
                    ubs_pkg::IDX_RBUF0, ubs_pkg::IDX_RBUF1: begin
                        tx_data_o <= pwdata_i[7:0];
                        tx_load_o[idx == ubs_pkg::IDX_RBUF1] <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // APB read path and zero-wait ready; unmapped reads give zero with error
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            pready_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            if (psel_i && !penable_i) begin
                case (idx)
                    ubs_pkg::IDX_TIMER2_UART0_CLOCK_SELECT_U0: prdata_o <= {24'h0, t2_u0_reg};
                    ubs_pkg::IDX_TIMER2_UART1_CLOCK_SELECT_U1: prdata_o <= {24'h0, t2_u1_reg};
                    ubs_pkg::IDX_PRESCALE: prdata_o <= {24'h0, scr_reg};
                    ubs_pkg::IDX_STAT0: prdata_o <= {24'h0, stat_reg[0]};
                    ubs_pkg::IDX_STAT1: prdata_o <= {24'h0, stat_reg[1]};
                    ubs_pkg::IDX_CTRL0: prdata_o <= {24'h0, ctl_reg[0]};
                    ubs_pkg::IDX_CTRL1: prdata_o <= {24'h0, ctl_reg[1]};
                    ubs_pkg::IDX_RBUF0: prdata_o <= {23'h0, rbuf_reg[0]};
                    ubs_pkg::IDX_RBUF1: prdata_o <= {23'h0, rbuf_reg[1]};
                    ubs_pkg::IDX_RELOAD1: prdata_o <= {24'h0, reload1_reg};
                    ubs_pkg::IDX_RELOAD2: prdata_o <= {16'h0, reload2_reg};
                    default: begin
                        prdata_o <= 32'h0000_0000;
                        pslverr_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Separate rx/tx requests and highest-priority slot
    // Error flags join the receive request when enabled
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= '0;
            irq_slot_o <= 4'h0;
            tx_tick_o <= '0;
        end else begin
            tx_tick_o <= tx_tick;
            for (int u = 0; u < NUM_UART; u++) begin
                irq_o[u].rx <= ctl_reg[u][ubs_pkg::CTL_RI_BIT] |
                    (stat_reg[u][ubs_pkg::STINT_BIT] & |stat_reg[u][3:1]);
                irq_o[u].tx <= tx_load_o[u];
            end
            if (irq_o[0].rx) irq_slot_o <= ubs_pkg::SLOT_U0_RX;
            else if (irq_o[0].tx) irq_slot_o <= ubs_pkg::SLOT_U0_TX;
            else if (irq_o[1].rx) irq_slot_o <= ubs_pkg::SLOT_U1_RX;
            else if (irq_o[1].tx) irq_slot_o <= ubs_pkg::SLOT_U1_TX;
            else irq_slot_o <= 4'h0;
        end
    end
endmodule

//--- tb/ubs_core_chk.sv
// Purpose: Port-level timing checks for ubs_core
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into every ubs_core instance
`timescale 1ns/1ps
module ubs_core_chk #(
    parameter int NUM_UART = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [NUM_UART-1:0] tx_load_o,
    input wire ubs_pkg::ubs_irq_t [NUM_UART-1:0] irq_o,
    input wire logic [3:0] irq_slot_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Bus phases of one transfer, and two cycles with no request
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_bufwr;
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == {18'h0, ubs_pkg::IDX_RBUF0, 2'b00};
    endsequence
    sequence s_no_irq;
        irq_o == '0 ##1 irq_o == '0;
    endsequence
    property p_ready; s_setup |=> pready_o; endproperty
    a_ready: assert property (p_ready) else $error("no ready in first access cycle");
    property p_pulse; pready_o |=> !pready_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_err; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
    a_err: assert property (p_err) else $error("refusal without ready or zero data");
    property p_load; s_bufwr |-> ##[0:2] tx_load_o[0]; endproperty
    a_load: assert property (p_load) else $error("buffer write did not load transmit");
    property p_load_one; tx_load_o[0] |=> !tx_load_o[0]; endproperty
    a_load_one: assert property (p_load_one) else $error("transmit load not a pulse");
    property p_tx_irq; tx_load_o[0] |-> ##[0:1] irq_o[0].tx; endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("no transmit request");
    property p_slot; irq_slot_o != 4'h0 |-> irq_slot_o >= 4'h7 && irq_slot_o <= 4'ha; endproperty
    a_slot: assert property (p_slot) else $error("slot outside seven to ten");
    property p_slot_idle; s_no_irq |=> irq_slot_o == 4'h0; endproperty
    a_slot_idle: assert property (p_slot_idle) else $error("slot without request");
endmodule
bind ubs_core ubs_core_chk #(.NUM_UART(NUM_UART)) ubs_core_chk_i (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tx_load_o(tx_load_o), .irq_o(irq_o), .irq_slot_o(irq_slot_o));

//--- tb/ubs_remote_tx.sv
// Purpose: Remote 9-bit UART sender on the receive line
// Assumes: Bit period given in clock cycles
// Notes: Line idles high (mark) between frames
`timescale 1ns/1ps
module ubs_remote_tx (
    input wire logic clk_i,
    output logic line_o
);
    initial line_o = 1'b1;
    task automatic send(input logic [8:0] d, input logic stop, input int per);
        logic [10:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (per - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask
endmodule

//--- tb/ubs_core_bench.sv
// Purpose: Self-checking bench for ubs_core
// Assumes: APB with zero wait states, remote sender on UART0
// Notes: Tick counts allow one tick of phase slack
`timescale 1ns/1ps
module ubs_core_bench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, r;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
    logic [1:0] rxd, tick, load;
    logic [7:0] txd, b;
    logic [3:0] slot;
    ubs_pkg::ubs_irq_t [1:0] irq;
    int miscompares = 0;
    int checked = 0;
    int seed = 32'h4bef;
    always #10 clk_i = ~clk_i;
    ubs_core ubs_core_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rxd_i(rxd), .tx_tick_o(tick),
        .tx_load_o(load), .tx_data_o(txd), .irq_o(irq), .irq_slot_o(slot));
    ubs_remote_tx ubs_remote_tx_i (.clk_i(clk_i), .line_o(rxd[0]));
    // Second receiver idles at mark level
    assign rxd[1] = 1'b1;
    task tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Ready, data and error are taken at the rising edge that sees ready high
    task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {18'h0, idx, 2'b00};
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            r = pready;
            q = prdata;
            err = pslverr;
            n++;
        end while (r !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, r}, 32'h1);
    endtask
    function automatic int tick_exp(int n, int range, int reload);
        return 256 / (n * (range - reload));
    endfunction
    task ticks(input int u, input int e);
        int c;
        c = 0;
        repeat (256) begin
            @(negedge clk_i);
            c += int'(tick[u]);
        end
        checked++;
        if (c < e - 1 || c > e + 1) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, c, e);
        end
    endtask
    task frame(input logic [8:0] d, input logic stop);
        ubs_remote_tx_i.send(d, stop, 32);
        repeat (4) @(posedge clk_i);
    endtask
    // Watchdog against a hung handshake or receiver
    initial begin
        repeat (40000) @(posedge clk_i);
        miscompares++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        apb(0, ubs_pkg::IDX_STAT0, 0); chk(q, 32'h0);
        apb(0, ubs_pkg::IDX_STAT1, 0); chk(q, 32'h0);
        apb(0, 12'h400, 0); chk({q[30:0], err}, 32'h1);
        for (int c = 0; c < 3; c++) begin
            apb(1, ubs_pkg::IDX_PRESCALE, c << 2);
            apb(0, ubs_pkg::IDX_PRESCALE, 0); chk(q & 32'hc, c << 2);
        end
        apb(1, ubs_pkg::IDX_TIMER2_UART0_CLOCK_SELECT_U0, 32'h30);
        apb(0, ubs_pkg::IDX_TIMER2_UART0_CLOCK_SELECT_U0, 0); chk(q & 32'h30, 32'h30);
        apb(1, ubs_pkg::IDX_TIMER2_UART0_CLOCK_SELECT_U0, 0);
        b = 8'($random(seed));
        apb(1, ubs_pkg::IDX_RBUF0, {24'h0, b});
        repeat (2) @(negedge clk_i);
        chk({24'h0, txd}, {24'h0, b});
        apb(1, ubs_pkg::IDX_CTRL0, 0); ticks(0, 256);
        apb(1, ubs_pkg::IDX_CTRL0, 2); ticks(0, 128);
        apb(1, ubs_pkg::IDX_PRESCALE, 0);
        apb(1, ubs_pkg::IDX_RELOAD1, 32'hff);
        apb(1, ubs_pkg::IDX_CTRL0, 1); ticks(0, tick_exp(4, 256, 255));
        apb(1, ubs_pkg::IDX_PRESCALE, 32'h4);
        apb(1, ubs_pkg::IDX_TIMER2_UART1_CLOCK_SELECT_U1, 32'h10);
        apb(1, ubs_pkg::IDX_RELOAD2, 32'hfffe);
        apb(1, ubs_pkg::IDX_CTRL1, 3); ticks(1, tick_exp(16, 65536, 65534));
        ticks(0, tick_exp(16, 256, 255));
        apb(1, ubs_pkg::IDX_PRESCALE, 32'hc); ticks(1, 0);
        apb(1, ubs_pkg::IDX_CTRL0, 32'he);
        b = 8'($random(seed));
        frame({1'b0, b}, 1'b1); chk({31'h0, irq[0].rx}, 32'h0);
        frame({1'b1, b}, 1'b1); chk({31'h0, irq[0].rx}, 32'h1);
        apb(0, ubs_pkg::IDX_RBUF0, 0); chk(q & 32'hff, {24'h0, b});
        apb(0, ubs_pkg::IDX_CTRL0, 0); chk(q & 32'h10, 32'h10);
        frame({1'b1, ~b}, 1'b1);
        apb(0, ubs_pkg::IDX_STAT0, 0); chk(q & 32'hf, 32'h2);
        apb(1, ubs_pkg::IDX_STAT0, 0);
        apb(0, ubs_pkg::IDX_STAT0, 0); chk(q & 32'hf, 32'h0);
        apb(1, ubs_pkg::IDX_CTRL0, 32'he);
        frame({1'b0, b | 8'h01}, 1'b0);
        apb(0, ubs_pkg::IDX_STAT0, 0); chk(q & 32'hf, 32'h8);
        apb(1, ubs_pkg::IDX_STAT0, 0);
        frame(9'h0, 1'b0); chk({31'h0, irq[0].rx}, 32'h0);
        apb(0, ubs_pkg::IDX_STAT0, 0); chk(q & 32'hf, 32'hc);
        apb(1, ubs_pkg::IDX_STAT0, 32'h1);
        frame(9'h0, 1'b0); chk({31'h0, irq[0].rx}, 32'h1);
        tally_and_finish;
    end
endmodule
